//--- sdci_host.sv
// Purpose: SPI master model standing in for the host controller
// Assumes: clk is the bench clock; each sclk phase lasts 4 clk
// Notes: sdi is inverted at frame end so a stale bit never passes for data
`timescale 1ns/100ps
module sdci_host (
	input wire logic clk,
	input wire logic sdo_line,
	output logic sclk,
	output logic cs_n,
	output logic sdi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	// Mode 0 when cpol is 0, mode 3 when 1; n of 0 gives an empty strobe
	task automatic xfer(input logic [15:0] w, input int n, input logic cpol, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk) sclk = cpol;
		repeat (4) @(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			sdi = w[i];
			repeat (4) @(negedge clk);
			rx = {rx[14:0], sdo_line};
			sclk = 1'b1;
			repeat (4) @(negedge clk);
		end
		sclk = cpol;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		sdi = ~sdi;
		repeat (12) @(negedge clk);
	endtask
endmodule

//--- sdci_interpreter.sv
// Purpose: SPI slave command interpreter for a nonvolatile digital potentiometer
// Assumes: SPI pins and strap pins are asynchronous to clk; clk much faster than sclk
// Notes: reset_n stands for power-on; the nonvolatile store powers up at its factory value
`timescale 1ns/100ps
module sdci_interpreter
	import sdci_pkg::*;
#(
	parameter int WORD_BITS = 16,
	parameter int DATA_BITS = 8,
	parameter int NUM_CH = 2,
	parameter int SAVE_CYCLES = SAVE_CYCLES_DFLT
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic write_protect_n,
	input wire logic preset_reload_pin_n,
	output logic sdo_o,
	output logic sdo_oe_n,
	output logic rdy_o,
	output logic rdy_oe_n,
	output logic [NUM_CH-1:0][DATA_BITS-1:0] wiper_setting_register
);
	localparam logic [DATA_BITS-1:0] MIDSCALE = DATA_BITS'(1) << (DATA_BITS - 1);
	localparam logic [DATA_BITS-1:0] FULLSCALE = '1;
	localparam logic [BITCNT_W-1:0] BITCNT_MAX = '1;
	// Daisy chain taps a fixed depth, so a long word still chains after sixteen clocks
	localparam int CHAIN_BITS = 16;

	logic [2:0] sclk_sy, cs_sy, pr_sy;
	logic [1:0] sdi_sy, wp_sy;
	logic sclk_rise, cs_rise, cs_fall, pr_rise, cs_high, wp_ok, pr_high;
	logic [WORD_BITS-1:0] shreg;
	logic [BITCNT_W-1:0] bitcnt;
	sdci_word_t rx_word, rep_word, ex;
	logic rep_valid, go, por_pend, ch_ok, allowed;
	logic [CNT_W-1:0] busy_cnt;
	logic busy;
	logic [NUM_CH-1:0][DATA_BITS-1:0] nonvolatile_store;
	logic [DATA_BITS-1:0] ex_data, rd_nv, rd_wiper;
	logic [NUM_CH-1:0] ch_sel;

	function automatic logic [DATA_BITS-1:0] step_value(input sdci_cmd_t c, input logic [DATA_BITS-1:0] v);
		logic [DATA_BITS-1:0] r;
		r = v;
		case (c)
			SDCI_SHR_ONE, SDCI_SHR_ALL: r = v >> 1;
			SDCI_SHL_ONE, SDCI_SHL_ALL: r = v[DATA_BITS-1] ? FULLSCALE : (v << 1);
			SDCI_DEC_ONE, SDCI_DEC_ALL: r = (v == '0) ? v : v - DATA_BITS'(1);
			SDCI_INC_ONE, SDCI_INC_ALL: r = (v == FULLSCALE) ? v : v + DATA_BITS'(1);
			default: r = v;
		endcase
		return r;
	endfunction

	function automatic logic is_repeatable(input sdci_cmd_t c);
		return c inside {SDCI_SHR_ONE, SDCI_SHR_ALL, SDCI_DEC_ONE, SDCI_DEC_ALL,
			SDCI_SHL_ONE, SDCI_SHL_ALL, SDCI_INC_ONE, SDCI_INC_ALL};
	endfunction

	// Pins cross in through two flops; a third stage only feeds edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_sy <= 3'h0;
			cs_sy <= 3'h7;
			pr_sy <= 3'h7;
			sdi_sy <= 2'h0;
			wp_sy <= 2'h3;
		end else begin
			sclk_sy <= {sclk_sy[1:0], sclk};
			cs_sy <= {cs_sy[1:0], cs_n};
			pr_sy <= {pr_sy[1:0], preset_reload_pin_n};
			sdi_sy <= {sdi_sy[0], sdi};
			wp_sy <= {wp_sy[0], write_protect_n};
		end
	end

	// Modes 0 and 3 both sample on the rising clock edge
	assign sclk_rise = sclk_sy[1] & ~sclk_sy[2];
	assign cs_high = cs_sy[1];
	assign cs_rise = cs_sy[1] & ~cs_sy[2];
	assign cs_fall = ~cs_sy[1] & cs_sy[2];
	assign pr_high = pr_sy[1];
	assign pr_rise = pr_sy[1] & ~pr_sy[2];
	assign wp_ok = wp_sy[1];
	assign busy = busy_cnt != '0;

	always_comb begin
		rx_word.command_code_bits = sdci_cmd_t'(shreg[WORD_BITS-1 -: CMD_W]);
		rx_word.register_select_bits = shreg[WORD_BITS-CMD_W-1 -: ADDR_W];
		rx_word.payload_bits = '0;
		rx_word.payload_bits[DATA_BITS-1:0] = shreg[DATA_BITS-1:0];
	end

	// Execute only at the end of the frame; an empty frame replays the last step command
	assign go = cs_rise & ~busy & (bitcnt != '0 | rep_valid);
	assign ex = (bitcnt != '0) ? rx_word : rep_word;
	assign ex_data = ex.payload_bits[DATA_BITS-1:0];
	assign ch_ok = ex.register_select_bits < ADDR_W'(NUM_CH);
	// Only SDCI_NV_TO_WIPER and SDCI_READ_NV get through write-protect; reload-all from the store is blocked
	assign allowed = wp_ok | ex.command_code_bits inside {SDCI_NV_TO_WIPER, SDCI_READ_NV};

	always_comb begin
		rd_nv = '0;
		rd_wiper = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			ch_sel[i] = ch_ok && ex.register_select_bits == ADDR_W'(i);
			if (ch_sel[i]) begin
				rd_nv = nonvolatile_store[i];
				rd_wiper = wiper_setting_register[i];
			end
		end
	end

	// Serial register: shifts MSB first, frozen during a save, loaded by readbacks
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg <= '0;
			bitcnt <= '0;
		end else if (cs_fall) begin
			bitcnt <= '0;
		end else if (!cs_high && sclk_rise && !busy) begin
			shreg <= {shreg[WORD_BITS-2:0], sdi_sy[1]};
			bitcnt <= (bitcnt == BITCNT_MAX) ? bitcnt : bitcnt + BITCNT_W'(1);
		end else if (go && allowed && ex.command_code_bits == SDCI_READ_NV) begin
			shreg <= WORD_BITS'(rd_nv);
		end else if (go && allowed && ex.command_code_bits == SDCI_READ_WIPER) begin
			shreg <= WORD_BITS'(rd_wiper);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rep_word <= '0;
			rep_valid <= 1'b0;
		end else if (go && bitcnt != '0) begin
			rep_word <= rx_word;
			// Any other command, NOP included, ends the replay and idles the logic
			rep_valid <= is_repeatable(rx_word.command_code_bits);
		end
	end

	// Store contents model the factory midscale value at power-on
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nonvolatile_store <= {NUM_CH{MIDSCALE}};
		end else if (go && allowed) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (ch_sel[i] && ex.command_code_bits == SDCI_SAVE_WIPER) begin
					nonvolatile_store[i] <= wiper_setting_register[i];
				end
				if (ch_sel[i] && ex.command_code_bits == SDCI_WRITE_NV) begin
					nonvolatile_store[i] <= ex_data;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			por_pend <= 1'b1;
		end else begin
			por_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wiper_setting_register <= {NUM_CH{MIDSCALE}};
		end else if (por_pend) begin
			wiper_setting_register <= nonvolatile_store;
		end else if (!pr_high) begin
			wiper_setting_register <= {NUM_CH{MIDSCALE}};
		end else if (pr_rise) begin
			wiper_setting_register <= nonvolatile_store;
		end else if (go && allowed) begin
			for (int i = 0; i < NUM_CH; i++) begin
				case (ex.command_code_bits)
					SDCI_NV_TO_WIPER: if (ch_sel[i]) begin
						wiper_setting_register[i] <= nonvolatile_store[i];
					end
					SDCI_WRITE_WIPER: if (ch_sel[i]) begin
						wiper_setting_register[i] <= ex_data;
					end
					SDCI_RELOAD_ALL: if (ex.register_select_bits == '0) begin
						wiper_setting_register[i] <= nonvolatile_store[i];
					end
					SDCI_SHR_ONE, SDCI_DEC_ONE, SDCI_SHL_ONE, SDCI_INC_ONE: if (ch_sel[i]) begin
						wiper_setting_register[i] <= step_value(ex.command_code_bits, wiper_setting_register[i]);
					end
					SDCI_SHR_ALL, SDCI_DEC_ALL, SDCI_SHL_ALL, SDCI_INC_ALL: begin
						wiper_setting_register[i] <= step_value(ex.command_code_bits, wiper_setting_register[i]);
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Saves run the full programming time; the other flagged commands hold busy for one cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_cnt <= '0;
		end else if (go && allowed && (ch_ok || ex.command_code_bits == SDCI_RELOAD_ALL)
				&& ex.command_code_bits inside {SDCI_SAVE_WIPER, SDCI_WRITE_NV}) begin
			busy_cnt <= CNT_W'(SAVE_CYCLES);
		end else if (go && allowed && ex.command_code_bits inside {SDCI_RELOAD_ALL, SDCI_READ_NV, SDCI_READ_WIPER}) begin
			busy_cnt <= CNT_W'(DONE_CYCLES);
		end else if (busy) begin
			busy_cnt <= busy_cnt - CNT_W'(1);
		end
	end

	// Open-drain pins: enable low pulls the line low, release lets the pull-up win
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sdo_o <= 1'b0;
			sdo_oe_n <= 1'b1;
			rdy_o <= 1'b0;
			rdy_oe_n <= 1'b1;
		end else begin
			sdo_o <= 1'b0;
			sdo_oe_n <= cs_high | shreg[CHAIN_BITS-1];
			rdy_o <= 1'b0;
			rdy_oe_n <= ~busy;
		end
	end

	// Helper for the lock length: a save must never hold the lock past its time
	logic [CNT_W-1:0] lock_len;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_len <= '0;
		end else if (!busy) begin
			lock_len <= '0;
		end else begin
			lock_len <= lock_len + CNT_W'(1);
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	shift_lock_a: assert property (busy && sclk_rise |=> $stable(shreg))
		else $error("serial register moved during a save");
	ready_low_a: assert property ($rose(busy) |=> !rdy_oe_n)
		else $error("ready not pulled low while busy");
	ready_done_a: assert property ($fell(busy) |=> rdy_oe_n)
		else $error("ready not released after save");
	sdo_release_a: assert property (cs_high |=> sdo_oe_n)
		else $error("serial output driven while deselected");
	mid_frame_a: assert property (!cs_rise && pr_high && !pr_rise && !por_pend |=> $stable(wiper_setting_register))
		else $error("wiper changed outside a frame end");
	protect_hold_a: assert property (go && !wp_ok && !(ex.command_code_bits inside {SDCI_NV_TO_WIPER, SDCI_READ_NV})
		&& pr_high && !pr_rise |=> $stable(wiper_setting_register) && $stable(nonvolatile_store))
		else $error("write-protect did not block a change");
	preset_mid_a: assert property (!pr_high && !por_pend |=> wiper_setting_register[0] == MIDSCALE)
		else $error("preset low did not force midscale");
	inc_step_a: assert property (go && allowed && pr_high && !pr_rise && ex.command_code_bits == SDCI_INC_ALL
		&& wiper_setting_register[0] != FULLSCALE |=> wiper_setting_register[0] == $past(wiper_setting_register[0]) + 1'b1)
		else $error("increment did not step by one");
	save_copy_a: assert property (go && allowed && ch_sel[0] && ex.command_code_bits == SDCI_SAVE_WIPER
		|=> nonvolatile_store[0] == $past(wiper_setting_register[0]) ##1 busy [*8])
		else $error("save did not copy wiper or lock");
	repeat_go_a: assert property (cs_rise && !busy && bitcnt == '0 && rep_valid |-> go && ex == rep_word)
		else $error("empty strobe did not replay command");

	// Readback, ready pulse, chaining and save lock length guards
	read_load_a: assert property (go && allowed && ch_sel[0] && ex.command_code_bits == SDCI_READ_WIPER
		|=> shreg == WORD_BITS'($past(wiper_setting_register[0])))
		else $error("readback did not load the serial register");
	rdy_pulse_a: assert property (go && allowed && ex.command_code_bits inside {SDCI_READ_NV, SDCI_READ_WIPER}
		|=> ##1 !rdy_oe_n ##1 rdy_oe_n)
		else $error("ready did not pulse after a readback");
	chain_out_a: assert property (!cs_high |=> sdo_oe_n == $past(shreg[CHAIN_BITS-1]))
		else $error("serial output did not follow the chain tap");
	lock_len_a: assert property (lock_len <= CNT_W'(SAVE_CYCLES))
		else $error("save lock held too long");

	// Store and wiper update guards
	nv_hold_a: assert property (!go |=> $stable(nonvolatile_store))
		else $error("store changed outside a frame end");
	absent_ch_a: assert property (go && !ch_ok && pr_high && !pr_rise
		&& !(ex.command_code_bits inside {SDCI_SHR_ALL, SDCI_DEC_ALL, SDCI_SHL_ALL, SDCI_INC_ALL, SDCI_RELOAD_ALL})
		|=> $stable(wiper_setting_register) && $stable(nonvolatile_store))
		else $error("absent channel command changed a value");
	reload_all_a: assert property (go && allowed && ex.command_code_bits == SDCI_RELOAD_ALL
		&& ex.register_select_bits == '0 && pr_high && !pr_rise |=> wiper_setting_register == $past(nonvolatile_store))
		else $error("reload did not copy the store");
	power_on_a: assert property (por_pend |=> wiper_setting_register == $past(nonvolatile_store))
		else $error("power-on did not load the wipers");
	write_wiper_a: assert property (go && allowed && pr_high && !pr_rise && ch_sel[0]
		&& ex.command_code_bits == SDCI_WRITE_WIPER |=> wiper_setting_register[0] == $past(ex_data))
		else $error("wiper write did not land");
	sat_top_a: assert property (go && allowed && pr_high && !pr_rise && ch_sel[0]
		&& ex.command_code_bits == SDCI_INC_ONE && wiper_setting_register[0] == FULLSCALE
		|=> wiper_setting_register[0] == FULLSCALE)
		else $error("increment passed full scale");
	step_floor_a: assert property (go && allowed && pr_high && !pr_rise && ex.command_code_bits == SDCI_SHR_ALL
		&& wiper_setting_register[0] == '0 |=> wiper_setting_register[0] == '0)
		else $error("right shift moved below zero");

	save_c: cover property (go && ex.command_code_bits == SDCI_SAVE_WIPER ##1 busy);
	readback_c: cover property (go && ex.command_code_bits == SDCI_READ_WIPER ##[1:50] cs_fall);
	replay_c: cover property (go && bitcnt == '0 && rep_valid);
	protect_c: cover property (go && !wp_ok);
	step_all_c: cover property (go && ex.command_code_bits == SDCI_INC_ALL);
endmodule

//--- sdci_pkg.sv
// Purpose: shared constants and types for the serial potentiometer command interpreter
// Assumes: 100 MHz system clock
// Notes: variant shape (word length, wiper width, channel count) is set by module parameters
package sdci_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SAVE_TIME_NS = 20_200_000;
	// Longest-time figure rounds down to whole cycles
	localparam int SAVE_CYCLES_DFLT = SAVE_TIME_NS / CLK_PERIOD_NS;
	localparam int DONE_CYCLES = 1;
	localparam int CNT_W = 22;

	localparam int CMD_W = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_MAX_W = 10;
	localparam int BITCNT_W = 5;

	typedef enum logic [3:0] {
		SDCI_NOP = 4'h0,
		SDCI_NV_TO_WIPER = 4'h1,
		SDCI_SAVE_WIPER = 4'h2,
		SDCI_WRITE_NV = 4'h3,
		SDCI_SHR_ONE = 4'h4,
		SDCI_SHR_ALL = 4'h5,
		SDCI_DEC_ONE = 4'h6,
		SDCI_DEC_ALL = 4'h7,
		SDCI_RELOAD_ALL = 4'h8,
		SDCI_READ_NV = 4'h9,
		SDCI_READ_WIPER = 4'ha,
		SDCI_WRITE_WIPER = 4'hb,
		SDCI_SHL_ONE = 4'hc,
		SDCI_SHL_ALL = 4'hd,
		SDCI_INC_ONE = 4'he,
		SDCI_INC_ALL = 4'hf
	} sdci_cmd_t;

	// One decoded serial word
	typedef struct packed {
		sdci_cmd_t command_code_bits;
		logic [ADDR_W-1:0] register_select_bits;
		logic [DATA_MAX_W-1:0] payload_bits;
	} sdci_word_t;
endpackage

//--- tb_sdci_interpreter.sv
// Purpose: self-checking bench for the dual-channel interpreter
// Assumes: pull-ups on SDO and ready, so each line equals its enable
// Notes: save time shortened to 20 clk to keep the run short
`timescale 1ns/100ps
module tb_sdci_interpreter import sdci_pkg::*; ;
	localparam int SAVE = 20;
	logic clk, reset_n, write_protect_n, preset_reload_pin_n;
	logic sclk, cs_n, sdi, sdo_o, sdo_oe_n, rdy_o, rdy_oe_n;
	logic [1:0][7:0] wiper_setting_register, exp_w, last_w;
	logic [1:0][7:0] q[$];
	logic [7:0] nv[2];
	logic [7:0] r;
	logic [15:0] rx;
	logic [31:0] seed = 32'd60924;
	int n_errors = 0;
	int num_checks = 0;
	int low_cnt = 0;
	int last_low = 0;

	sdci_interpreter #(.WORD_BITS(16), .DATA_BITS(8), .NUM_CH(2), .SAVE_CYCLES(SAVE)) sdci_interpreter_i (
		.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.write_protect_n(write_protect_n), .preset_reload_pin_n(preset_reload_pin_n),
		.sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .rdy_o(rdy_o), .rdy_oe_n(rdy_oe_n),
		.wiper_setting_register(wiper_setting_register));
	sdci_host sdci_host_i (.clk(clk), .sdo_line(sdo_oe_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// The note is queued before the frame, so the watcher never sees a change first
	task automatic note(input logic [1:0][7:0] w);
		if (w !== exp_w)
			q.push_back(w);
		exp_w = w;
	endtask

	task automatic cmd(input sdci_cmd_t c, input logic [3:0] a, input logic [7:0] d, input int n,
			input logic [1:0][7:0] w);
		note(w);
		sdci_host_i.xfer({c, a, d}, n, 1'(rnd()), rx);
	endtask

	task automatic wait_rdy();
		for (int i = 0; i < 100 && rdy_oe_n !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
		if (rdy_oe_n !== 1'b1) begin
			n_errors++;
			results();
		end
	endtask

	always @(negedge clk) begin
		if (rdy_oe_n === 1'b0)
			low_cnt++;
		else if (low_cnt != 0) begin
			last_low = low_cnt;
			low_cnt = 0;
		end
		if (reset_n && wiper_setting_register !== last_w) begin
			if (q.size() == 0)
				check(wiper_setting_register, last_w);
			else
				check(wiper_setting_register, q.pop_front());
		end
		last_w = wiper_setting_register;
	end

	initial begin
		reset_n = 1'b0;
		write_protect_n = 1'b1;
		preset_reload_pin_n = 1'b1;
		exp_w = 16'h8080;
		last_w = 16'h8080;
		nv = '{8'h80, 8'h80};
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		check(wiper_setting_register, 16'h8080);
		$display("test power_on done");
		r = 8'(rnd());
		cmd(SDCI_WRITE_WIPER, 4'h1, r, 16, {r, 8'h80});
		cmd(SDCI_WRITE_WIPER, 4'h0, 8'hfe, 16, {r, 8'hfe});
		cmd(SDCI_INC_ONE, 4'h0, 8'h00, 16, {r, 8'hff});
		cmd(SDCI_INC_ONE, 4'h0, 8'h00, 0, {r, 8'hff});
		cmd(SDCI_DEC_ONE, 4'h0, 8'h00, 16, {r, 8'hfe});
		cmd(SDCI_DEC_ONE, 4'h0, 8'h00, 0, {r, 8'hfd});
		cmd(SDCI_SHR_ALL, 4'h0, 8'h00, 16, {r >> 1, 8'h7e});
		cmd(SDCI_SHL_ONE, 4'h1, 8'h00, 16, {r & 8'hfe, 8'h7e});
		cmd(SDCI_INC_ALL, 4'h0, 8'h00, 16, {exp_w[1] + 8'h01, 8'h7f});
		cmd(SDCI_DEC_ALL, 4'h0, 8'h00, 16, {exp_w[1] - 8'h01, 8'h7e});
		cmd(SDCI_SHL_ALL, 4'h0, 8'h00, 16, {exp_w[1][7] ? 8'hff : exp_w[1] << 1, 8'hfc});
		cmd(SDCI_SHR_ONE, 4'h0, 8'h00, 16, {exp_w[1], 8'h7e});
		check({15'h0000, sdo_oe_n}, 16'h0001);
		$display("test step done");
		last_low = 0;
		cmd(SDCI_SAVE_WIPER, 4'h1, 8'h00, 16, exp_w);
		nv[1] = exp_w[1];
		wait_rdy();
		check(16'(last_low), 16'(SAVE));
		cmd(SDCI_READ_WIPER, 4'h0, 8'h00, 16, exp_w);
		cmd(SDCI_NOP, 4'h0, 8'h00, 16, exp_w);
		check(rx, {8'h00, exp_w[0]});
		last_low = 0;
		cmd(SDCI_READ_NV, 4'h1, 8'h00, 16, exp_w);
		check(16'(last_low), 16'h0001);
		cmd(SDCI_NOP, 4'h0, 8'h00, 16, exp_w);
		check(rx, {8'h00, nv[1]});
		$display("test readback done");
		cmd(SDCI_WRITE_WIPER, 4'h1, 8'h33, 16, {8'h33, exp_w[0]});
		write_protect_n = 1'b0;
		cmd(SDCI_WRITE_WIPER, 4'h0, 8'h11, 16, exp_w);
		cmd(SDCI_NV_TO_WIPER, 4'h1, 8'h00, 16, {nv[1], exp_w[0]});
		write_protect_n = 1'b1;
		cmd(SDCI_WRITE_NV, 4'h0, 8'h5a, 16, exp_w);
		nv[0] = 8'h5a;
		wait_rdy();
		cmd(SDCI_WRITE_WIPER, 4'h3, 8'h22, 16, exp_w);
		cmd(SDCI_RELOAD_ALL, 4'h0, 8'h00, 16, {nv[1], nv[0]});
		cmd(SDCI_WRITE_WIPER, 4'h0, 8'h01, 16, {nv[1], 8'h01});
		$display("test protect done");
		note(16'h8080);
		preset_reload_pin_n = 1'b0;
		repeat (12) @(negedge clk);
		note({nv[1], nv[0]});
		preset_reload_pin_n = 1'b1;
		repeat (12) @(negedge clk);
		cmd(SDCI_NOP, 4'h0, 8'h00, 16, exp_w);
		check(16'(q.size()), 16'h0000);
		check({14'h0000, sdo_o, rdy_o}, 16'h0000);
		$display("test preset done");
		results();
	end
endmodule
